// ==== logic/uwmcs_pkg.sv ====
package uwmcs_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_PORT = 8'h0C;
    localparam logic [7:0] OFS_PIN = 8'h10;

    // Field positions.
    localparam int CTRL_WIRE_LSB = 4;
    localparam int CTRL_CS_LSB = 2;
    localparam int CTRL_SOFT_BIT = 1;
    localparam int CTRL_TOG_BIT = 0;
    localparam int STAT_START_BIT = 7;
    localparam int STAT_WRAP_BIT = 6;
    localparam int PORT_DIR_LSB = 4;
    localparam int PIN_DO = 0;
    localparam int PIN_SDI = 1;
    localparam int PIN_SCK = 2;

    // Reset values and counts.
    localparam logic [1:0] WIRE_RST = 2'h0;
    localparam logic [1:0] CS_RST = 2'h0;
    localparam logic [7:0] SHREG_RST = 8'h00;
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [3:0] CNT_MAX = 4'hF;
    localparam logic [2:0] PORT_RST = 3'h0;
    localparam logic [2:0] DIR_RST = 3'h0;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        WIRE_OFF = 2'b00,
        WIRE_THREE = 2'b01,
        WIRE_TWO = 2'b10,
        WIRE_TWO_HOLD = 2'b11
    } uwmcs_wire_e;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ = 2'b10
    } uwmcs_bus_e;

    function automatic logic uwmcs_is_two(input logic [1:0] wire_sel);
        return wire_sel[1];
    endfunction

    function automatic logic uwmcs_is_ext(input logic [1:0] cs_sel);
        return cs_sel[1];
    endfunction

endpackage

// ==== logic/uwmcs_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module uwmcs_sync
    import uwmcs_pkg::*;
#(
    parameter int W = 3
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Levels.
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // Lines idle high behind their pull-ups, so start there to avoid a false edge.
            meta_q <= '1;
            sync_out <= '1;
        end else if (ce) begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== logic/uwmcs_start_det.sv ====
`timescale 1ns/1ps
`default_nettype none
module uwmcs_start_det
    import uwmcs_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Synchronised lines.
    input wire logic sda,
    input wire logic scl,
    output logic start
);
    logic sda_prev_q;
    logic scl_prev_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_prev_q <= 1'b1;
            scl_prev_q <= 1'b0;
            start <= 1'b0;
        end else if (ce) begin
            sda_prev_q <= sda;
            scl_prev_q <= scl;
            // A falling data line while the clock stays high marks a start.
            start <= sda_prev_q & ~sda & scl & scl_prev_q;
        end
    end
endmodule
`default_nettype wire

// ==== logic/uwmcs_top.sv ====
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module uwmcs_top
    import uwmcs_pkg::*;
(
    // Clock, reset and freeze.
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic CE,
    // AHB-Lite slave.
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Timer compare match, same clock.
    input wire logic TIMER_MATCH,
    // Serial data-out pin.
    output logic SERIAL_OUT_PIN_OUT,
    output logic SERIAL_OUT_PIN_OE,
    output logic SERIAL_OUT_PIN_PU,
    // Serial data-in pin, SDA in two-wire modes.
    input wire logic SERIAL_IN_PIN_IN,
    output logic SERIAL_IN_PIN_OUT,
    output logic SERIAL_IN_PIN_OE,
    output logic SERIAL_IN_PIN_PU,
    // Shift clock pin, SCL in two-wire modes.
    input wire logic SHIFT_CLK_PIN_IN,
    output logic SHIFT_CLK_PIN_OUT,
    output logic SHIFT_CLK_PIN_OE,
    output logic SHIFT_CLK_PIN_PU
);
    uwmcs_bus_e bus_q;
    logic [7:0] addr_q;
    logic [1:0] wire_q, cs_q;
    logic soft_sel_q, soft_pulse_q, tog_pulse_q;
    logic [7:0] sh_q, sh_d;
    logic latch_q;
    logic [3:0] cnt_q;
    logic start_q, wrap_q;
    logic [2:0] port_q, dir_q;
    logic di_prev_q, sck_prev_q;
    logic [2:0] pins_s;
    logic start_ev;
    logic wr_en, ctrl_we, stat_we, data_we, port_we;
    logic two, ext, sck_rise, sck_fall;
    logic sh_tick, cnt_tick, din, lv, scl_hold;
    logic [31:0] rd_mux;

    uwmcs_sync #(
        .W(3)
    ) u_sync (
        .clk(CLK_SYS),
        .rst_n(RESET_N),
        .ce(CE),
        .async_in({SHIFT_CLK_PIN_IN, SERIAL_IN_PIN_IN, 1'b0}),
        .sync_out(pins_s)
    );

    uwmcs_start_det u_start (
        .clk(CLK_SYS),
        .rst_n(RESET_N),
        .ce(CE),
        .sda(pins_s[PIN_SDI]),
        .scl(pins_s[PIN_SCK]),
        .start(start_ev)
    );

    // Bus slave: zero-wait writes, one wait state on reads so data comes from a flop.
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            bus_q <= BUS_IDLE;
            addr_q <= OFS_CTRL;
            HREADYOUT <= 1'b1;
            HRDATA <= WORD_ZERO;
            HRESP <= 1'b0;
        end else if (CE) begin
            HRESP <= 1'b0;
            case (bus_q)
                BUS_READ: begin
                    HRDATA <= rd_mux;
                    HREADYOUT <= 1'b1;
                    bus_q <= BUS_IDLE;
                end
                BUS_IDLE, BUS_WRITE: begin
                    if (HSEL && HREADY && HTRANS[1]) begin
                        // Unmapped upper bits or sub-word sizes decode to no register.
                        addr_q <= (HADDR[31:8] == 24'h00_0000 && HSIZE == HSIZE_WORD)
                            ? HADDR[7:0] : 8'hFF;
                        bus_q <= HWRITE ? BUS_WRITE : BUS_READ;
                        HREADYOUT <= HWRITE;
                    end else begin
                        bus_q <= BUS_IDLE;
                    end
                end
                default: begin
                    bus_q <= BUS_IDLE;
                    HREADYOUT <= 1'b1;
                end
            endcase
        end
    end

    assign wr_en = CE && bus_q == BUS_WRITE;
    assign ctrl_we = wr_en && addr_q == OFS_CTRL;
    assign stat_we = wr_en && addr_q == OFS_STAT;
    assign data_we = wr_en && addr_q == OFS_DATA;
    assign port_we = wr_en && addr_q == OFS_PORT;

    always_comb begin
        rd_mux = WORD_ZERO;
        case (addr_q)
            OFS_CTRL: begin
                // Strobe bits are left at zero on read.
                rd_mux[CTRL_WIRE_LSB +: 2] = wire_q;
                rd_mux[CTRL_CS_LSB +: 2] = cs_q;
            end
            OFS_STAT: begin
                rd_mux[STAT_START_BIT] = start_q;
                rd_mux[STAT_WRAP_BIT] = wrap_q;
                rd_mux[3:0] = cnt_q;
            end
            OFS_DATA: rd_mux[7:0] = sh_q;
            OFS_PORT: begin
                rd_mux[2:0] = port_q;
                rd_mux[PORT_DIR_LSB +: 3] = dir_q;
            end
            OFS_PIN: rd_mux[2:1] = pins_s[2:1];
            default: rd_mux = WORD_ZERO;
        endcase
    end

    // Control register and strobes.
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            wire_q <= WIRE_RST;
            cs_q <= CS_RST;
            soft_sel_q <= 1'b0;
            soft_pulse_q <= 1'b0;
            tog_pulse_q <= 1'b0;
        end else if (CE) begin
            // A write becomes exactly one pulse cycle.
            soft_pulse_q <= ctrl_we && HWDATA[CTRL_SOFT_BIT];
            tog_pulse_q <= ctrl_we && HWDATA[CTRL_TOG_BIT];
            if (ctrl_we) begin
                wire_q <= HWDATA[CTRL_WIRE_LSB +: 2];
                cs_q <= HWDATA[CTRL_CS_LSB +: 2];
                // With an external source this bit selects the counter clock.
                soft_sel_q <= HWDATA[CTRL_SOFT_BIT];
            end
        end
    end

    assign two = uwmcs_is_two(wire_q);
    assign ext = uwmcs_is_ext(cs_q);
    assign sck_rise = pins_s[PIN_SCK] & ~sck_prev_q;
    assign sck_fall = ~pins_s[PIN_SCK] & sck_prev_q;

    always_comb begin
        case (cs_q)
            2'b00: begin
                sh_tick = soft_pulse_q;
                cnt_tick = soft_pulse_q;
                din = di_prev_q;
            end
            2'b01: begin
                sh_tick = TIMER_MATCH;
                cnt_tick = TIMER_MATCH;
                din = pins_s[PIN_SDI];
            end
            default: begin
                sh_tick = cs_q[0] ? sck_fall : sck_rise;
                // Toggle strobes drive the counter so a master sees the end early.
                cnt_tick = soft_sel_q ? tog_pulse_q : (sck_rise | sck_fall);
                din = pins_s[PIN_SDI];
            end
        endcase
    end

    // A bus write in the same cycle as a shift wins; the shift is lost.
    always_comb begin
        if (data_we) begin
            sh_d = HWDATA[7:0];
        end else if (sh_tick) begin
            sh_d = {sh_q[6:0], din};
        end else begin
            sh_d = sh_q;
        end
    end

    // With internal sources the next value is shown at once, so the pin flop
    // changes on the same edge as the shifter.
    assign lv = ext ? latch_q : sh_d[7];

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            sh_q <= SHREG_RST;
            latch_q <= 1'b0;
            di_prev_q <= 1'b1;
            sck_prev_q <= 1'b1;
        end else if (CE) begin
            sh_q <= sh_d;
            di_prev_q <= pins_s[PIN_SDI];
            sck_prev_q <= pins_s[PIN_SCK];
            // Latch closes on the sampling edge and opens on the other one.
            if (cs_q[0] ? sck_rise : sck_fall) begin
                latch_q <= sh_q[7];
            end
        end
    end

    // Counter and flags; a start event beats a clear in the same cycle, but a status write beats a count and its wrap.
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            cnt_q <= CNT_RST;
            wrap_q <= 1'b0;
            start_q <= 1'b0;
        end else if (CE) begin
            if (stat_we) begin
                cnt_q <= HWDATA[3:0];
            end else if (cnt_tick) begin
                cnt_q <= cnt_q + 4'h1;
            end
            if (cnt_tick && !stat_we && cnt_q == CNT_MAX) begin
                wrap_q <= 1'b1;
            end else if (stat_we && HWDATA[STAT_WRAP_BIT]) begin
                wrap_q <= 1'b0;
            end
            if ((two && start_ev)
                || (!two && ext && !soft_sel_q && (sck_rise || sck_fall))) begin
                start_q <= 1'b1;
            end else if (stat_we && HWDATA[STAT_START_BIT]) begin
                start_q <= 1'b0;
            end
        end
    end

    // Holds exist only in two-wire modes.
    assign scl_hold = two && (start_q || (wire_q == WIRE_TWO_HOLD && wrap_q));

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            port_q <= PORT_RST;
            dir_q <= DIR_RST;
        end else if (CE) begin
            if (port_we) begin
                port_q <= HWDATA[2:0];
                dir_q <= HWDATA[PORT_DIR_LSB +: 3];
            end else if (tog_pulse_q) begin
                port_q[PIN_SCK] <= ~port_q[PIN_SCK];
            end
        end
    end

    // Pin drivers, all registered.
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            SERIAL_OUT_PIN_OUT <= 1'b0;
            SERIAL_OUT_PIN_OE <= 1'b0;
            SERIAL_OUT_PIN_PU <= 1'b0;
            SERIAL_IN_PIN_OUT <= 1'b0;
            SERIAL_IN_PIN_OE <= 1'b0;
            SERIAL_IN_PIN_PU <= 1'b0;
            SHIFT_CLK_PIN_OUT <= 1'b0;
            SHIFT_CLK_PIN_OE <= 1'b0;
            SHIFT_CLK_PIN_PU <= 1'b0;
        end else if (CE) begin
            SERIAL_OUT_PIN_OE <= dir_q[PIN_DO];
            SERIAL_OUT_PIN_PU <= ~dir_q[PIN_DO] & port_q[PIN_DO];
            SERIAL_OUT_PIN_OUT <= (wire_q == WIRE_THREE) ? lv : port_q[PIN_DO];
            if (two) begin
                // Open drain: only ever drive low.
                SERIAL_IN_PIN_OUT <= 1'b0;
                SERIAL_IN_PIN_OE <= dir_q[PIN_SDI] & (~lv | ~port_q[PIN_SDI]);
                SERIAL_IN_PIN_PU <= 1'b0;
                SHIFT_CLK_PIN_OUT <= 1'b0;
                SHIFT_CLK_PIN_OE <= dir_q[PIN_SCK] & (~port_q[PIN_SCK] | scl_hold);
                SHIFT_CLK_PIN_PU <= 1'b0;
            end else begin
                SERIAL_IN_PIN_OUT <= port_q[PIN_SDI];
                SERIAL_IN_PIN_OE <= dir_q[PIN_SDI];
                SERIAL_IN_PIN_PU <= ~dir_q[PIN_SDI] & port_q[PIN_SDI];
                SHIFT_CLK_PIN_OUT <= port_q[PIN_SCK];
                SHIFT_CLK_PIN_OE <= dir_q[PIN_SCK];
                SHIFT_CLK_PIN_PU <= ~dir_q[PIN_SCK] & port_q[PIN_SCK];
            end
        end
    end

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);

    chk_off_gpio: assert property (CE && wire_q == WIRE_OFF |=>
        SERIAL_OUT_PIN_OUT == $past(port_q[PIN_DO]) && SHIFT_CLK_PIN_OE == $past(dir_q[PIN_SCK]))
        else $error("mode off does not act as gpio");
    chk_do_latch: assert property (CE && wire_q == WIRE_THREE |=>
        SERIAL_OUT_PIN_OUT == $past(lv) && SERIAL_OUT_PIN_OE == $past(dir_q[PIN_DO]))
        else $error("data out not from latch");
    chk_sck_plain: assert property (CE && wire_q == WIRE_THREE |=>
        SHIFT_CLK_PIN_OUT == $past(port_q[PIN_SCK]) && SHIFT_CLK_PIN_OE == $past(dir_q[PIN_SCK]))
        else $error("clock pin changed in three-wire");
    chk_sda_drain: assert property (CE && two |=> !SERIAL_IN_PIN_OUT &&
        SERIAL_IN_PIN_OE == $past(dir_q[PIN_SDI] & (~lv | ~port_q[PIN_SDI])))
        else $error("sda open drain wrong");
    chk_scl_hold: assert property (CE && two && start_q && dir_q[PIN_SCK] |=>
        SHIFT_CLK_PIN_OE && !SHIFT_CLK_PIN_OUT)
        else $error("scl not held after start");
    chk_wrap_hold: assert property (CE && wire_q == WIRE_TWO_HOLD && wrap_q
        && dir_q[PIN_SCK] |=> SHIFT_CLK_PIN_OE)
        else $error("scl not held after wrap");
    chk_soft_idle: assert property (cs_q == 2'b00 && !soft_pulse_q |->
        !sh_tick && !cnt_tick)
        else $error("clock without strobe");
    chk_soft_step: assert property (CE && cs_q == 2'b00 && soft_pulse_q && !stat_we
        |=> cnt_q == $past(cnt_q) + 4'h1)
        else $error("soft strobe did not count");
    chk_wrap_set: assert property (CE && cnt_tick && !stat_we && cnt_q == CNT_MAX
        |=> wrap_q && cnt_q == CNT_RST)
        else $error("wrap flag not set");
    chk_start_keep: assert property (CE && start_q && !(stat_we && HWDATA[STAT_START_BIT])
        |=> start_q)
        else $error("start flag lost");
    chk_tog_flip: assert property (CE && tog_pulse_q && !port_we |=>
        port_q[PIN_SCK] != $past(port_q[PIN_SCK]))
        else $error("toggle did not flip");
    chk_one_pulse: assert property (CE && (soft_pulse_q || tog_pulse_q) && !ctrl_we |=>
        !soft_pulse_q && !tog_pulse_q)
        else $error("strobe held too long");

    cov_soft_wrap: cover property (cs_q == 2'b00 && soft_pulse_q && cnt_q == CNT_MAX);
    cov_start_hold: cover property (two && start_ev ##1 start_q ##[1:20] !start_q);
    cov_ext_shift: cover property (ext && soft_sel_q && tog_pulse_q ##[1:8] sh_tick);
endmodule
`default_nettype wire

// ==== verification/uwmcs_far_end.sv ====
`timescale 1ns/1ps
`default_nettype none
module uwmcs_far_end (
    // Device drive on the shared lines.
    input wire logic sda_oe,
    input wire logic sda_out,
    input wire logic scl_oe,
    input wire logic scl_out,
    // Resolved line levels.
    output logic sda,
    output logic scl
);
    logic sda_low = 1'b0;
    logic scl_low = 1'b0;

    // Both lines carry a pull-up, so a line that nobody pulls low reads high.
    assign sda = ~((sda_oe & ~sda_out) | sda_low);
    assign scl = ~((scl_oe & ~scl_out) | scl_low);

    task automatic hold_sda(input logic v);
        sda_low <= ~v;
    endtask

    // Edges sit 13 ns off the bench grid so that they never race its clock.
    // The clock rests high between frames, and each bit takes 320 ns.
    // Data moves a quarter bit before the fall and holds past the rise, so either
    // sampling edge sees the same bit.
    task automatic send_bits(input logic [7:0] b, input int n);
        #13;
        for (int i = n - 1; i >= 0; i--) begin
            sda_low = ~b[i];
            #80 scl_low = 1'b1;
            #160 scl_low = 1'b0;
            #80;
        end
        sda_low = 1'b0;
    endtask

    // Data falls while the clock is high, then lets go once the clock is held.
    task automatic start_cond();
        #13 sda_low = 1'b1;
        #320 sda_low = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== verification/test_usi_wire_mode_clock_select.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_usi_wire_mode_clock_select
    import uwmcs_pkg::*;
;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] data;
        logic [7:0] port;
        logic [8:0] pins;
    } uwmcs_row_s;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic timer_match = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic do_out, do_oe, do_pu;
    logic si_out, si_oe, si_pu;
    logic sck_out, sck_oe, sck_pu;
    logic sda, scl, scl_pull;
    logic [31:0] rd;
    int bad_count = 0;
    int n_checks = 0;
    uwmcs_row_s rows [7];

    assign scl_pull = sck_oe & ~sck_out;

    always #20 clk = ~clk;

    uwmcs_top dut (
        .CLK_SYS(clk), .RESET_N(rst_n), .CE(1'b1),
        .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(HSIZE_WORD),
        .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(hresp), .TIMER_MATCH(timer_match),
        .SERIAL_OUT_PIN_OUT(do_out), .SERIAL_OUT_PIN_OE(do_oe), .SERIAL_OUT_PIN_PU(do_pu),
        .SERIAL_IN_PIN_IN(sda), .SERIAL_IN_PIN_OUT(si_out), .SERIAL_IN_PIN_OE(si_oe),
        .SERIAL_IN_PIN_PU(si_pu), .SHIFT_CLK_PIN_IN(scl), .SHIFT_CLK_PIN_OUT(sck_out),
        .SHIFT_CLK_PIN_OE(sck_oe), .SHIFT_CLK_PIN_PU(sck_pu)
    );

    uwmcs_far_end far (
        .sda_oe(si_oe), .sda_out(si_out), .scl_oe(sck_oe), .scl_out(sck_out),
        .sda(sda), .scl(scl)
    );

    // Each pin is reduced to pulled low, driven high and pull-up request.
    function automatic logic [8:0] pins();
        return {do_oe & ~do_out, do_oe & do_out, do_pu, si_oe & ~si_out, si_oe & si_out, si_pu,
            sck_oe & ~sck_out, sck_oe & sck_out, sck_pu};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Entered just after a rising edge; the master never assumes a latency.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00);
        check(rd, exp);
        check({31'h0, hresp}, 32'h0000_0000);
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            timer_match <= 1'b1;
            @(posedge clk);
            timer_match <= 1'b0;
            @(posedge clk);
        end
    endtask

    // Shifts a frame from the far side; the count sees both edges of each bit.
    task automatic ext(input logic [7:0] c, input logic [7:0] b, input int n);
        bus(1'b1, OFS_DATA, 8'h00);
        bus(1'b1, OFS_STAT, 8'hC0);
        bus(1'b1, OFS_CTRL, c);
        far.send_bits(b, n);
        cyc(6);
        rchk(OFS_DATA, {24'h00_0000, b});
        bus(1'b0, OFS_STAT, 8'h00);
        check(rd & 32'h0000_000F, 32'(2 * n));
    endtask

    initial begin
        #400000;
        bad_count++;
        finish_test();
    end

    initial begin
        rows = '{'{8'h00, 8'h00, 8'h53, 9'h08C}, '{8'h10, 8'h00, 8'h15, 9'h101},
            '{8'h10, 8'h80, 8'h67, 9'h052}, '{8'h20, 8'h80, 8'h67, 9'h040},
            '{8'h20, 8'h00, 8'h27, 9'h060}, '{8'h30, 8'h80, 8'h63, 9'h044},
            '{8'h20, 8'h80, 8'h25, 9'h060}};
        repeat (8) @(posedge clk);
        check({23'h0, pins()}, 32'h0000_0000);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int a = 0; a < 16; a += 4) begin
            rchk(a[7:0], 32'h0000_0000);
        end
        rchk(OFS_PIN, 32'h0000_0006);
        bus(1'b1, 8'h20, 8'hFF);
        rchk(8'h20, 32'h0000_0000);
        // Flags are cleared late so that a start seen while settling cannot hold SCL.
        foreach (rows[i]) begin
            bus(1'b1, OFS_CTRL, rows[i].ctrl);
            bus(1'b1, OFS_DATA, rows[i].data);
            bus(1'b1, OFS_PORT, rows[i].port);
            cyc(6);
            bus(1'b1, OFS_STAT, 8'hC0);
            cyc(4);
            check({23'h0, pins()}, {23'h0, rows[i].pins});
        end
        bus(1'b1, OFS_CTRL, 8'h10);
        bus(1'b1, OFS_PORT, 8'h10);
        bus(1'b1, OFS_DATA, 8'h7F);
        bus(1'b1, OFS_STAT, 8'hCF);
        far.hold_sda(1'b0);
        cyc(4);
        bus(1'b1, OFS_CTRL, 8'h12);
        cyc(4);
        rchk(OFS_DATA, 32'h0000_00FE);
        rchk(OFS_STAT, 32'h0000_0040);
        check({31'h0, do_out}, 32'h0000_0001);
        rchk(OFS_CTRL, 32'h0000_0010);
        far.hold_sda(1'b1);
        cyc(4);
        bus(1'b1, OFS_CTRL, 8'h12);
        cyc(4);
        rchk(OFS_DATA, 32'h0000_00FD);
        rchk(OFS_STAT, 32'h0000_0041);
        bus(1'b1, OFS_STAT, 8'hC0);
        bus(1'b1, OFS_CTRL, 8'h00);
        tick(1);
        bus(1'b1, OFS_CTRL, 8'h16);
        tick(3);
        rchk(OFS_STAT, 32'h0000_0003);
        rchk(OFS_DATA, 32'h0000_00EF);
        ext(8'h18, 8'h0A, 4);
        ext(8'h1C, 8'h05, 3);
        bus(1'b1, OFS_CTRL, 8'h1A);
        bus(1'b1, OFS_STAT, 8'hC0);
        bus(1'b1, OFS_CTRL, 8'h1B);
        cyc(4);
        rchk(OFS_PORT, 32'h0000_0014);
        bus(1'b1, OFS_PORT, 8'h54);
        bus(1'b1, OFS_CTRL, 8'h1B);
        cyc(4);
        check({31'h0, scl_pull}, 32'h0000_0001);
        bus(1'b1, OFS_CTRL, 8'h1B);
        cyc(6);
        rchk(OFS_STAT, 32'h0000_0003);
        bus(1'b1, OFS_CTRL, 8'h20);
        bus(1'b1, OFS_DATA, 8'h80);
        bus(1'b1, OFS_PORT, 8'h67);
        cyc(6);
        bus(1'b1, OFS_STAT, 8'hC0);
        far.start_cond();
        cyc(6);
        check({31'h0, scl_pull}, 32'h0000_0001);
        rchk(OFS_STAT, 32'h0000_0080);
        bus(1'b1, OFS_STAT, 8'h40);
        cyc(4);
        check({31'h0, scl_pull}, 32'h0000_0001);
        bus(1'b1, OFS_STAT, 8'h80);
        cyc(4);
        check({31'h0, scl_pull}, 32'h0000_0000);
        // Only the mode with the extra hold may keep SCL low after a wrap.
        for (int m = 2; m < 4; m++) begin
            bus(1'b1, OFS_CTRL, 8'(m << 4));
            bus(1'b1, OFS_DATA, 8'hC0);
            bus(1'b1, OFS_STAT, 8'hCF);
            bus(1'b1, OFS_CTRL, 8'(m << 4) | 8'h02);
            cyc(4);
            check({31'h0, scl_pull}, 32'(m - 2));
            bus(1'b1, OFS_STAT, 8'h40);
            cyc(4);
            check({31'h0, scl_pull}, 32'h0000_0000);
        end
        finish_test();
    end
endmodule
`default_nettype wire
